// file: bench/lbr_host_reader.sv
// Host-side reader model: drains message characters and collects whole messages.
// Assumes the reporter holds each character until it is accepted.
`timescale 1ns/1ps
module lbr_host_reader (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_stall,
    input  wire       i_msg_valid,
    input  wire [7:0] i_msg_char,
    input  wire       i_msg_last,
    output reg        o_msg_ready
);
    string      cur;
    string      done_q[$];
    logic [2:0] cnt;
    string      t;
    initial begin
        o_msg_ready = 1'b0;
        cnt = 3'h0;
        cur = "";
    end
    // A slow host accepts only one cycle in eight, to exercise holding.
    always @(posedge i_clk) begin
        cnt <= cnt + 3'h1;
        o_msg_ready <= !i_rst && (!i_stall || cnt == 3'h5);
        if (!i_rst && i_msg_valid && o_msg_ready) begin
            t = " ";
            t[0] = (^i_msg_char === 1'bx) ? 8'h3F : i_msg_char;
            cur = {cur, t};
            if (i_msg_last) begin
                done_q.push_back(cur);
                cur = "";
            end
        end
    end
endmodule

// file: bench/lbr_reporter_bench.sv
// Self-checking bench for the response reporter with a host reader model.
// Assumes the kind codes and characters of lbr_defines.vh.
`timescale 1ns/1ps
`include "lbr_defines.vh"
module lbr_reporter_bench;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        req_valid = 1'b0;
    logic [4:0]  req_kind = 5'h00;
    logic [7:0]  req_port = 8'h00;
    logic [31:0] req_arg = 32'h0;
    logic [31:0] req_aux = 32'h0;
    logic        txt_valid = 1'b0;
    logic [7:0]  txt_char = 8'h00;
    logic        txt_last = 1'b0;
    logic        ts_check = 1'b0;
    logic [15:0] ts_addr = 16'h0000;
    logic        stall = 1'b0;
    wire         o_req_ready, o_txt_ready, o_msg_valid, o_msg_last, msg_ready;
    wire [7:0]   o_msg_char;
    wire         o_ts_done, o_ts_ok;
    wire [4:0]   o_ts_stream;
    wire [6:0]   o_ts_slot;
    logic [31:0] seed = 32'h00001B7D;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    string       exp_q[$];
    string       got, want;

    always #2.5 i_clk = ~i_clk;

    lbr_reporter i_lbr_reporter (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(req_valid),
        .i_req_kind(req_kind), .i_req_port(req_port), .i_req_arg(req_arg),
        .i_req_aux(req_aux), .o_req_ready(o_req_ready), .i_txt_valid(txt_valid),
        .i_txt_char(txt_char), .i_txt_last(txt_last), .o_txt_ready(o_txt_ready),
        .o_msg_valid(o_msg_valid), .o_msg_char(o_msg_char), .o_msg_last(o_msg_last),
        .i_msg_ready(msg_ready), .i_ts_check(ts_check), .i_ts_addr(ts_addr),
        .o_ts_done(o_ts_done), .o_ts_ok(o_ts_ok), .o_ts_stream(o_ts_stream),
        .o_ts_slot(o_ts_slot));
    lbr_host_reader i_reader (.i_clk(i_clk), .i_rst(i_rst), .i_stall(stall),
        .i_msg_valid(o_msg_valid), .i_msg_char(o_msg_char), .i_msg_last(o_msg_last),
        .o_msg_ready(msg_ready));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] pc();
        logic [31:0] r;
        r = rnd();
        return 8'h41 + {3'h0, r[4:0]};
    endfunction
    function automatic string ch(logic [7:0] c);
        string t;
        t = " ";
        t[0] = c;
        return t;
    endfunction
    function automatic string hx(logic [31:0] v, int n);
        string       t;
        logic [3:0]  d;
        t = "";
        for (int i = n - 1; i >= 0; i--) begin
            d = v[4*i +: 4];
            t = {t, ch((d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d})};
        end
        return t;
    endfunction
    function automatic string fmt(logic [4:0] k, logic [7:0] p, logic [31:0] a,
                                  logic [31:0] x, string t);
        string h;
        h = hx({24'h0, p}, 2);
        case (k)
            `LBR_K_STORE:    return {"SM", hx({31'h0, a[0]}, 1)};
            `LBR_K_PENERGY:  return {"SP", h, hx({31'h0, a[0]}, 1)};
            `LBR_K_DENERGY:  return {"SPX", h, hx(a, 1)};
            `LBR_K_POLNORM:  return {"Sn", h};
            `LBR_K_POLREV:   return {"Sr", h};
            `LBR_K_RING:     return {"SR", h};
            `LBR_K_FLASH:    return {"SQ", h};
            `LBR_K_OFFHOOK:  return {"SF", h};
            `LBR_K_ONHOOK:   return {"SN", h};
            `LBR_K_PDIGIT:   return {"ST", h, ch(a[7:0])};
            `LBR_K_DDIGIT:   return {"STX", h, ch(a[7:0])};
            `LBR_K_WAITING:  return {"SW", h};
            `LBR_K_CNUMBER:  return {"DD", h, t};
            `LBR_K_CNAME:    return {"DN", h, t};
            `LBR_K_TDONE:    return {"SE", h};
            `LBR_K_GDONE:    return {"SEX", h};
            `LBR_K_CONNECT:  return {a[0] ? "SB" : "SC", h};
            `LBR_K_HOLD:     return {"SH", h};
            `LBR_K_DISCON:   return {"SI", h};
            `LBR_K_LISTEN:   return {"SL", h};
            `LBR_K_AUDIO:    return {"SM", h};
            `LBR_K_XMIT:     return {"SX", h};
            `LBR_K_PRESET:   return {"RP", h};
            `LBR_K_LOCATION: return {"QL", h, hx(a, 2)};
            `LBR_K_OUTQUERY: return {"QO", hx(a, 5), ch(a[27:20]), a[31] ? hx(x, 5) : ""};
            `LBR_K_VERSION:  return {"VC", hx(a, 4), hx(a >> 16, 4), ch(x[15:8]), ch(x[7:0])};
            `LBR_K_CLKFAULT: return {"EC", hx(a & 32'h33, 2)};
            `LBR_K_UNDEF:    return {"U", t};
            default:         return "U";
        endcase
    endfunction

    task automatic chk(input logic c, input string what);
        comparisons++;
        if (c !== 1'b1) begin
            failures++;
            $display("CHECK FAILED %s expected 1 seen %b", what, c);
        end
    endtask

    // Drives one request and its text payload; expectation is queued before the take.
    task automatic send(input logic [4:0] k);
        logic [7:0]  p;
        logic [31:0] a;
        logic [31:0] x;
        logic        rdy;
        string       t;
        int          n;
        a = rnd();
        p = a[15:8];
        a = rnd();
        a[7:0] = pc();
        a[27:20] = pc();
        x = rnd();
        x[15:8] = pc();
        x[7:0] = pc();
        t = "";
        n = (k == `LBR_K_CNUMBER || k == `LBR_K_CNAME || k == `LBR_K_UNDEF) ? 1 + p[1:0] : 0;
        for (int i = 0; i < n; i++) t = {t, ch(pc())};
        exp_q.push_back(fmt(k, p, a, x, t));
        req_valid <= 1'b1;
        req_kind <= k;
        req_port <= p;
        req_arg <= a;
        req_aux <= x;
        do begin
            @(negedge i_clk);
            rdy = o_req_ready;
            @(posedge i_clk);
        end while (rdy !== 1'b1);
        req_valid <= 1'b0;
        for (int i = 0; i < n; i++) begin
            txt_valid <= 1'b1;
            txt_char <= t[i];
            txt_last <= (i == n - 1);
            do begin
                @(negedge i_clk);
                rdy = o_txt_ready;
                @(posedge i_clk);
            end while (rdy !== 1'b1);
        end
        txt_valid <= 1'b0;
        // An idle edge keeps the next call from lowering and raising valid in one step.
        if (n == 0) @(posedge i_clk);
    endtask

    task automatic ts(input logic [15:0] ad);
        logic ok;
        ok = (ad[15:8] <= 8'h1F) && (ad[7:0] <= 8'h7F);
        ts_check <= 1'b1;
        ts_addr <= ad;
        @(posedge i_clk);
        ts_check <= 1'b0;
        @(negedge i_clk);
        chk(o_ts_done === 1'b1 && o_ts_ok === ok && o_ts_stream === ad[12:8]
            && o_ts_slot === ad[6:0], "timeslot");
        @(negedge i_clk);
        chk(o_ts_done === 1'b0, "timeslot pulse");
        @(posedge i_clk);
    endtask

    always @(negedge i_clk) begin
        while (i_reader.done_q.size() > 0) begin
            got = i_reader.done_q.pop_front();
            want = (exp_q.size() > 0) ? exp_q.pop_front() : "none";
            comparisons++;
            if (got != want) begin
                failures++;
                $display("CHECK FAILED message expected %s seen %s", want, got);
            end
        end
    end

    // Ceiling allows 182 messages, 150 of them with a slow host, with margin.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            finish_test();
        end
    end

    task finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        logic [31:0] r;
        int          w;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 32; k++) send(k[4:0]);
        stall <= 1'b1;
        fork
            for (int n = 0; n < 150; n++) begin
                r = rnd();
                send(r[4:0]);
            end
            begin
                ts(16'h0000);
                ts(16'h1F7F);
                ts(16'h2000);
                ts(16'h1F80);
                ts(16'hFFFF);
                for (int n = 0; n < 40; n++) begin
                    r = rnd();
                    ts(r[15:0] & 16'h3FFF);
                end
            end
        join
        w = 0;
        while (exp_q.size() > 0 && w < 5000) begin
            @(posedge i_clk);
            w++;
        end
        @(posedge i_clk);
        chk(exp_q.size() == 0, "all messages delivered");
        finish_test();
    end
endmodule

// file: bench/lbr_reporter_props.sv
// Port checker for the response reporter: handshakes, message holding, timeslot checks.
// Assumes one clock and a synchronous active-high reset; attached by bind.
`timescale 1ns/1ps
module lbr_reporter_props (
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_req_valid,
    input wire        o_req_ready,
    input wire        o_txt_ready,
    input wire        o_msg_valid,
    input wire [7:0]  o_msg_char,
    input wire        o_msg_last,
    input wire        i_msg_ready,
    input wire        i_ts_check,
    input wire [15:0] i_ts_addr,
    input wire        o_ts_done,
    input wire        o_ts_ok,
    input wire [4:0]  o_ts_stream,
    input wire [6:0]  o_ts_slot
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_take;
        i_req_valid && o_req_ready;
    endsequence
    sequence s_ts;
        i_ts_check ##1 o_ts_done;
    endsequence
    sequence s_slot_free;
        !o_msg_valid || i_msg_ready;
    endsequence
    a_ts_answer: assert property (i_ts_check |-> s_ts)
        else $error("timeslot answer missing");
    a_ts_range: assert property (i_ts_check |=> o_ts_ok ==
        ($past(i_ts_addr[15:8]) <= 8'h1F && $past(i_ts_addr[7:0]) <= 8'h7F))
        else $error("timeslot range verdict wrong");
    a_ts_split: assert property (i_ts_check |=> o_ts_stream == $past(i_ts_addr[12:8])
        && o_ts_slot == $past(i_ts_addr[6:0])) else $error("timeslot fields wrong");
    a_ts_hold: assert property (!i_ts_check |=> !o_ts_done && $stable(o_ts_ok)
        && $stable(o_ts_slot) && $stable(o_ts_stream)) else $error("timeslot outputs moved");
    a_msg_stands: assert property (o_msg_valid && !i_msg_ready |=> o_msg_valid
        && $stable(o_msg_char) && $stable(o_msg_last)) else $error("message char dropped");
    a_first_char: assert property (s_take ##1 s_slot_free |=> o_msg_valid)
        else $error("message not started");
    a_take_busy: assert property (s_take |=> !o_req_ready)
        else $error("request port still open");
    a_text_gate: assert property (o_txt_ready |-> !o_req_ready)
        else $error("text taken while idle");
    a_last_valid: assert property (o_msg_last |-> o_msg_valid)
        else $error("last flag without valid");
    a_reset_out: assert property ($past(i_rst) |-> o_req_ready && !o_msg_valid && !o_ts_done)
        else $error("outputs not cleared by reset");
endmodule

bind lbr_reporter lbr_reporter_props i_lbr_reporter_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
    .o_txt_ready(o_txt_ready), .o_msg_valid(o_msg_valid), .o_msg_char(o_msg_char),
    .o_msg_last(o_msg_last), .i_msg_ready(i_msg_ready), .i_ts_check(i_ts_check),
    .i_ts_addr(i_ts_addr), .o_ts_done(o_ts_done), .o_ts_ok(o_ts_ok),
    .o_ts_stream(o_ts_stream), .o_ts_slot(o_ts_slot));

// file: logic/lbr_defines.vh
// Constants shared by the loop board response reporter files.
// Assumes inclusion by bare name from the reporter and timeslot check design files of the block.
`ifndef LBR_DEFINES_VH
`define LBR_DEFINES_VH

// Message kinds presented on the request port.
`define LBR_K_STORE     5'h00
`define LBR_K_PENERGY   5'h01
`define LBR_K_DENERGY   5'h02
`define LBR_K_POLNORM   5'h03
`define LBR_K_POLREV    5'h04
`define LBR_K_RING      5'h05
`define LBR_K_FLASH     5'h06
`define LBR_K_OFFHOOK   5'h07
`define LBR_K_ONHOOK    5'h08
`define LBR_K_PDIGIT    5'h09
`define LBR_K_DDIGIT    5'h0A
`define LBR_K_WAITING   5'h0B
`define LBR_K_CNUMBER   5'h0C
`define LBR_K_CNAME     5'h0D
`define LBR_K_TDONE     5'h0E
`define LBR_K_GDONE     5'h0F
`define LBR_K_CONNECT   5'h10
`define LBR_K_HOLD      5'h11
`define LBR_K_DISCON    5'h12
`define LBR_K_LISTEN    5'h13
`define LBR_K_AUDIO     5'h14
`define LBR_K_XMIT      5'h15
`define LBR_K_PRESET    5'h16
`define LBR_K_LOCATION  5'h17
`define LBR_K_OUTQUERY  5'h18
`define LBR_K_VERSION   5'h19
`define LBR_K_UNDEF     5'h1A
`define LBR_K_CLKFAULT  5'h1B

// Message characters.
`define LBR_CH_ZERO     8'h30
`define LBR_CH_B        8'h42
`define LBR_CH_C        8'h43
`define LBR_CH_D        8'h44
`define LBR_CH_E        8'h45
`define LBR_CH_F        8'h46
`define LBR_CH_H        8'h48
`define LBR_CH_I        8'h49
`define LBR_CH_L        8'h4C
`define LBR_CH_M        8'h4D
`define LBR_CH_N        8'h4E
`define LBR_CH_O        8'h4F
`define LBR_CH_P        8'h50
`define LBR_CH_Q        8'h51
`define LBR_CH_R        8'h52
`define LBR_CH_S        8'h53
`define LBR_CH_T        8'h54
`define LBR_CH_U        8'h55
`define LBR_CH_V        8'h56
`define LBR_CH_W        8'h57
`define LBR_CH_X        8'h58
`define LBR_CH_LN       8'h6E
`define LBR_CH_LR       8'h72

// Clock fault mask: bus clock A, bus clock B, master PLL, frame boundary.
`define LBR_CLK_MASK    8'h33

// Switching bus geometry.
`define LBR_BUS_STREAMS 32
`define LBR_BUS_SLOTS   128
`define LBR_BUS_KHZ     8192

`endif

// file: logic/lbr_hex_conv.v
// Turns a row of nibbles into upper-case hexadecimal ASCII characters.
// Purely combinational; nibble k appears as character k.
`timescale 1ns/1ps
module lbr_hex_conv #(
    parameter N = 18
) (
    input  wire [4*N-1:0] i_nib,
    output wire [8*N-1:0] o_chr
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_nib
            wire [3:0] nib;
            assign nib = i_nib[4*g +: 4];
            assign o_chr[8*g +: 8] = (nib < 4'hA) ? ({4'h0, nib} + 8'h30)
                                                  : ({4'h0, nib} + 8'h37);
        end
    endgenerate
endmodule

// file: logic/lbr_reporter.v
// Response reporter: formats board events and replies into text messages.
// Assumes one requester on the same clock that presents events in the order they
// occurred, and a host-side reader that drains characters with valid and ready.
`timescale 1ns/1ps
`include "lbr_defines.vh"

module lbr_reporter #(
    parameter BUF_CHARS = 16
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_req_valid,
    input  wire [4:0]  i_req_kind,
    input  wire [7:0]  i_req_port,
    input  wire [31:0] i_req_arg,
    input  wire [31:0] i_req_aux,
    output wire        o_req_ready,
    input  wire        i_txt_valid,
    input  wire [7:0]  i_txt_char,
    input  wire        i_txt_last,
    output wire        o_txt_ready,
    output reg         o_msg_valid,
    output reg  [7:0]  o_msg_char,
    output reg         o_msg_last,
    input  wire        i_msg_ready,
    input  wire        i_ts_check,
    input  wire [15:0] i_ts_addr,
    output wire        o_ts_done,
    output wire        o_ts_ok,
    output wire [4:0]  o_ts_stream,
    output wire [6:0]  o_ts_slot
);
    localparam BW = 8 * BUF_CHARS;

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_EMIT = 3'b010;
    localparam [2:0] ST_TEXT = 3'b100;

    reg  [2:0]    state;
    reg  [BW-1:0] msg_buf;
    reg  [4:0]    cnt;
    reg  [4:0]    next_len;
    reg           has_text;
    reg           next_text;
    reg  [BW-1:0] next_buf;
    wire [71:0]   conv_in;
    wire [143:0]  hc;
    wire [31:0]   conv_arg;
    wire [7:0]    p_hi;
    wire [7:0]    p_lo;
    wire          can_load;
    wire          take_req;

    // Result digits are ASCII 0 or 1.
    function [7:0] dig;
        input b;
        begin
            dig = `LBR_CH_ZERO | {7'h00, b};
        end
    endfunction

    // Bits for the absent legacy buses are forced to zero in the fault mask.
    assign conv_arg = (i_req_kind == `LBR_K_CLKFAULT) ?
                      {i_req_arg[31:8], i_req_arg[7:0] & `LBR_CLK_MASK} :
                      i_req_arg;
    assign conv_in  = {i_req_aux, conv_arg, i_req_port};

    lbr_hex_conv #(
        .N (18)
    ) u_hex (
        .i_nib (conv_in),
        .o_chr (hc)
    );

    lbr_ts_check #(
        .STREAMS (`LBR_BUS_STREAMS),
        .SLOTS   (`LBR_BUS_SLOTS)
    ) u_ts (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_ts_check  (i_ts_check),
        .i_ts_addr   (i_ts_addr),
        .o_ts_done   (o_ts_done),
        .o_ts_ok     (o_ts_ok),
        .o_ts_stream (o_ts_stream),
        .o_ts_slot   (o_ts_slot)
    );

    assign p_lo = hc[7:0];
    assign p_hi = hc[15:8];

    wire [7:0] an [0:7];
    wire [7:0] xn [0:7];
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_chars
            assign an[g] = hc[8*(g+2) +: 8];
            assign xn[g] = hc[8*(g+10) +: 8];
        end
    endgenerate

    // One request at a time keeps messages in arrival order with nothing dropped.
    assign o_req_ready = (state == ST_IDLE);
    assign take_req    = i_req_valid && o_req_ready;
    assign can_load    = !o_msg_valid || i_msg_ready;
    assign o_txt_ready = (state == ST_TEXT) && can_load;

    always @* begin
        next_buf  = {BW{1'b0}};
        next_len  = 5'h00;
        next_text = 1'b0;
        case (i_req_kind)
            `LBR_K_STORE: begin
                next_buf[BW-1 -: 24] = {`LBR_CH_S, `LBR_CH_M, dig(i_req_arg[0])};
                next_len = 5'h03;
            end
            `LBR_K_PENERGY: begin
                next_buf[BW-1 -: 40] = {`LBR_CH_S, `LBR_CH_P, p_hi, p_lo,
                                        dig(i_req_arg[0])};
                next_len = 5'h05;
            end
            `LBR_K_DENERGY: begin
                next_buf[BW-1 -: 48] = {`LBR_CH_S, `LBR_CH_P, `LBR_CH_X, p_hi, p_lo,
                                        an[0]};
                next_len = 5'h06;
            end
            `LBR_K_POLNORM: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_LN, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_POLREV: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_LR, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_RING: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_R, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_FLASH: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_Q, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_OFFHOOK: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_F, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_ONHOOK: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_N, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_PDIGIT: begin
                next_buf[BW-1 -: 40] = {`LBR_CH_S, `LBR_CH_T, p_hi, p_lo,
                                        i_req_arg[7:0]};
                next_len = 5'h05;
            end
            `LBR_K_DDIGIT: begin
                next_buf[BW-1 -: 48] = {`LBR_CH_S, `LBR_CH_T, `LBR_CH_X, p_hi, p_lo,
                                        i_req_arg[7:0]};
                next_len = 5'h06;
            end
            `LBR_K_WAITING: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_W, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_CNUMBER: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_D, `LBR_CH_D, p_hi, p_lo};
                next_len  = 5'h04;
                next_text = 1'b1;
            end
            `LBR_K_CNAME: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_D, `LBR_CH_N, p_hi, p_lo};
                next_len  = 5'h04;
                next_text = 1'b1;
            end
            `LBR_K_TDONE: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_E, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_GDONE: begin
                next_buf[BW-1 -: 40] = {`LBR_CH_S, `LBR_CH_E, `LBR_CH_X, p_hi, p_lo};
                next_len = 5'h05;
            end
            `LBR_K_CONNECT: begin
                // Bit 0 of the argument reports that the port is already in use.
                next_buf[BW-1 -: 32] = {`LBR_CH_S, i_req_arg[0] ? `LBR_CH_B : `LBR_CH_C,
                                        p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_HOLD: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_H, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_DISCON: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_I, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_LISTEN: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_L, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_AUDIO: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_M, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_XMIT: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_S, `LBR_CH_X, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_PRESET: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_R, `LBR_CH_P, p_hi, p_lo};
                next_len = 5'h04;
            end
            `LBR_K_LOCATION: begin
                next_buf[BW-1 -: 48] = {`LBR_CH_Q, `LBR_CH_L, p_hi, p_lo,
                                        an[1], an[0]};
                next_len = 5'h06;
            end
            `LBR_K_OUTQUERY: begin
                next_buf[BW-1 -: 64] = {`LBR_CH_Q, `LBR_CH_O, an[4], an[3], an[2],
                                        an[1], an[0], i_req_arg[27:20]};
                next_len = 5'h08;
                if (i_req_arg[31]) begin
                    next_buf[BW-65 -: 40] = {xn[4], xn[3], xn[2], xn[1], xn[0]};
                    next_len = 5'h0D;
                end
            end
            `LBR_K_VERSION: begin
                next_buf[BW-1 -: 96] = {`LBR_CH_V, `LBR_CH_C, an[3], an[2], an[1], an[0],
                                        an[7], an[6], an[5], an[4],
                                        i_req_aux[15:8], i_req_aux[7:0]};
                next_len = 5'h0C;
            end
            `LBR_K_CLKFAULT: begin
                next_buf[BW-1 -: 32] = {`LBR_CH_E, `LBR_CH_C, an[1], an[0]};
                next_len = 5'h04;
            end
            `LBR_K_UNDEF: begin
                next_buf[BW-1 -: 8] = `LBR_CH_U;
                next_len  = 5'h01;
                next_text = 1'b1;
            end
            default: begin
                // An unknown kind still yields a bare error marker so nothing vanishes.
                next_buf[BW-1 -: 8] = `LBR_CH_U;
                next_len = 5'h01;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            state       <= ST_IDLE;
            msg_buf     <= {BW{1'b0}};
            cnt         <= 5'h00;
            has_text    <= 1'b0;
            o_msg_valid <= 1'b0;
            o_msg_char  <= 8'h00;
            o_msg_last  <= 1'b0;
        end else begin
            // A drained register drops its last flag too, so last never stands alone.
            if (can_load) begin
                o_msg_valid <= 1'b0;
                o_msg_last  <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (take_req) begin
                        msg_buf  <= next_buf;
                        cnt      <= next_len;
                        has_text <= next_text;
                        state    <= ST_EMIT;
                    end
                end
                ST_EMIT: begin
                    if (can_load) begin
                        o_msg_valid <= 1'b1;
                        o_msg_char  <= msg_buf[BW-1 -: 8];
                        o_msg_last  <= (cnt == 5'h01) && !has_text;
                        msg_buf     <= {msg_buf[BW-9:0], 8'h00};
                        cnt         <= cnt - 5'h01;
                        if (cnt == 5'h01) begin
                            state <= has_text ? ST_TEXT : ST_IDLE;
                        end
                    end
                end
                ST_TEXT: begin
                    // Caller data and the echoed command pass through one character at a time.
                    if (can_load && i_txt_valid) begin
                        o_msg_valid <= 1'b1;
                        o_msg_char  <= i_txt_char;
                        o_msg_last  <= i_txt_last;
                        if (i_txt_last) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: logic/lbr_ts_check.v
// Checks a four-digit bus timeslot address and splits it into stream and slot.
// Assumes the address comes from logic on the same clock.
`timescale 1ns/1ps
`include "lbr_defines.vh"
module lbr_ts_check #(
    parameter STREAMS = `LBR_BUS_STREAMS,
    parameter SLOTS   = `LBR_BUS_SLOTS
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_ts_check,
    input  wire [15:0] i_ts_addr,
    output reg         o_ts_done,
    output reg         o_ts_ok,
    output reg  [4:0]  o_ts_stream,
    output reg  [6:0]  o_ts_slot
);
    wire in_range;
    // Upper two digits pick the stream, lower two the slot in it.
    assign in_range = ({24'h0, i_ts_addr[15:8]} < STREAMS) &&
                      ({24'h0, i_ts_addr[7:0]} < SLOTS);

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_ts_done   <= 1'b0;
            o_ts_ok     <= 1'b0;
            o_ts_stream <= 5'h00;
            o_ts_slot   <= 7'h00;
        end else begin
            o_ts_done <= i_ts_check;
            if (i_ts_check) begin
                o_ts_ok     <= in_range;
                // Every stream and slot of the bus is reachable.
                o_ts_stream <= i_ts_addr[12:8];
                o_ts_slot   <= i_ts_addr[6:0];
            end
        end
    end
endmodule
